// ==== ms_trail_overhead_inserter.sv ====
// Multiplex section trail source: inserts parity, remote error and remote defect overhead.
// Assumes the frame clock, data and start come from another domain and are slow
// enough (at least 4 sys_clk cycles per half period) to be sampled by sys_clk.
`timescale 1ns/10ps
`include "trail_overhead_map.svh"

module ms_trail_overhead_inserter #(
    // Octets per row; overhead positions assume at least 145 columns
    parameter logic [12:0] NUM_COLS = `FRAME_COLS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic adapted_frame_clock_in,
    input wire logic adapted_frame_start_in,
    input wire trail_overhead_pkg::octet_t adapted_frame_data_in,
    input wire logic [8:0] remote_error_count_in,
    input wire logic remote_defect_in,
    input wire trail_overhead_pkg::prot_mode_t prot_mode_in,
    output logic trail_frame_clock_out,
    output logic trail_frame_start_out,
    output trail_overhead_pkg::octet_t trail_frame_data_out
);
    import trail_overhead_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Link sampling

    logic clk_s1_r, clk_s2_r, clk_s3_r; // Frame clock synchroniser and edge history
    logic fs_s1_r, fs_s2_r; // Frame start synchroniser
    octet_t dat_s1_r, dat_s2_r; // Data synchroniser

    // Two flops on every link input, a third on the clock for edge history; data and start are read from the second stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_s1_r <= 1'b0;
            clk_s2_r <= 1'b0;
            clk_s3_r <= 1'b0;
            fs_s1_r <= 1'b0;
            fs_s2_r <= 1'b0;
            dat_s1_r <= 8'h00;
            dat_s2_r <= 8'h00;
        end else begin
            clk_s1_r <= adapted_frame_clock_in;
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
            fs_s1_r <= adapted_frame_start_in;
            fs_s2_r <= fs_s1_r;
            dat_s1_r <= adapted_frame_data_in;
            dat_s2_r <= dat_s1_r;
        end
    end

    // One strobe per rising frame clock edge marks a new octet
    wire strobe = clk_s2_r & ~clk_s3_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame position

    logic [12:0] col_r; // Column of the last octet
    logic [3:0] row_r; // Row of the last octet
    logic [5:0] lane_r; // Parity lane of the last octet

    // Frame start forces the origin, so a slip in the stream realigns at once
    wire col_wrap = (col_r == NUM_COLS - 13'd1);
    wire [12:0] cur_col = (fs_s2_r | col_wrap) ? 13'h0000 : col_r + 13'd1;
    wire row_wrap = (row_r == `FRAME_ROWS - 4'd1);
    wire [3:0] cur_row = fs_s2_r ? 4'h0 : (col_wrap ? (row_wrap ? 4'h0 : row_r + 4'd1) : row_r);
    wire lane_wrap = (lane_r == `BIP_LANES - 6'd1);
    wire [5:0] cur_lane = (fs_s2_r | col_wrap | lane_wrap) ? 6'h00 : lane_r + 6'd1;

    // Byte class decode
    wire in_regenerator_overhead = (cur_row < `REGENERATOR_OVERHEAD_ROWS) && (cur_col < `OH_COLS);
    wire is_par = (cur_row == `PAR_ROW) && (cur_col < `PAR_COL_END);
    wire is_prot = (cur_row == `PROT_ROW) && (cur_col == `PROT_COL);
    wire is_err = (cur_row == `ERR_ROW) && (cur_col == `ERR_COL);

    // Track the position of each accepted octet
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            col_r <= NUM_COLS - 13'd1;
            row_r <= `FRAME_ROWS - 4'd1;
            lane_r <= `BIP_LANES - 6'd1;
        end else if (strobe) begin
            col_r <= cur_col;
            row_r <= cur_row;
            lane_r <= cur_lane;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Overhead values

    octet_t acc_r [0:47]; // Running parity per lane for this frame
    octet_t bip_r [0:47]; // Finished parity of the previous frame

    // Remote error count clipped to one octet
    wire err_big = (remote_error_count_in > 9'h0FF); // Count does not fit one octet
    wire [7:0] err_byte = err_big ? `ERR_MAX : remote_error_count_in[7:0];

    // Incoming codes 110 and 111 in bits 6-8 are forbidden unless the ring owns these bits
    wire [2:0] k_in = dat_s2_r[2:0];
    wire k_reserved = (k_in == `AIS_CODE) || (k_in == `RDI_CODE);
    wire [2:0] k_out = remote_defect_in ? `RDI_CODE
                     : (prot_mode_in == PROT_SPRING) ? k_in
                     : k_reserved ? `CLEAR_CODE
                     : k_in;

    // Output octet selection; everything else passes untouched
    wire [7:0] byte_nxt = is_par ? bip_r[cur_lane]
                        : is_err ? err_byte
                        : is_prot ? {dat_s2_r[7:3], k_out}
                        : dat_s2_r;

    // Parity accumulation over the outgoing octets; regenerator overhead skipped
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 48; i++) begin
                acc_r[i] <= 8'h00;
                bip_r[i] <= 8'h00;
            end
        end else if (strobe && fs_s2_r) begin
            // First octet is regenerator overhead, so the new sum starts empty
            for (int i = 0; i < 48; i++) begin
                bip_r[i] <= acc_r[i];
                acc_r[i] <= 8'h00;
            end
        end else if (strobe && !in_regenerator_overhead) begin
            acc_r[cur_lane] <= acc_r[cur_lane] ^ byte_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output stage

    // Data and start change on the strobe, the clock rises one cycle later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trail_frame_data_out <= 8'h00;
            trail_frame_start_out <= 1'b0;
            trail_frame_clock_out <= 1'b0;
        end else begin
            trail_frame_clock_out <= clk_s3_r;
            if (strobe) begin
                trail_frame_data_out <= byte_nxt;
                trail_frame_start_out <= fs_s2_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic prot_pulse_r; // Protection byte just emitted
    logic [1:0] rdi_frames_r; // Protection bytes seen while the defect stays active

    // Helper for the defect reaction bound
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prot_pulse_r <= 1'b0;
            rdi_frames_r <= 2'h0;
        end else begin
            prot_pulse_r <= strobe && is_prot;
            if (!remote_defect_in)
                rdi_frames_r <= 2'h0;
            else if (strobe && is_prot && rdi_frames_r != 2'h3)
                rdi_frames_r <= rdi_frames_r + 2'h1;
        end
    end

    chk_defect_code_set: assert property (@(posedge sys_clk) disable iff (rst)
        prot_pulse_r && rdi_frames_r >= `RDI_LIMIT_FRAMES |-> trail_frame_data_out[2:0] == `RDI_CODE)
        else $error("defect code missing in protection byte");
    chk_no_reserved_code: assert property (@(posedge sys_clk) disable iff (rst)
        prot_pulse_r && !$past(remote_defect_in) && prot_mode_in != PROT_SPRING
        |-> trail_frame_data_out[2:0] != `AIS_CODE && trail_frame_data_out[2:0] != `RDI_CODE)
        else $error("reserved code sent without defect");
    chk_clear_replace: assert property (@(posedge sys_clk) disable iff (rst)
        strobe && is_prot && !remote_defect_in && prot_mode_in != PROT_SPRING && k_reserved
        |=> trail_frame_data_out[2:0] == `CLEAR_CODE)
        else $error("reserved code not replaced by zero");
    chk_pass_normal: assert property (@(posedge sys_clk) disable iff (rst)
        strobe && is_prot && !remote_defect_in && !k_reserved
        |=> trail_frame_data_out == $past(dat_s2_r))
        else $error("normal protection code altered");
    chk_ring_pass: assert property (@(posedge sys_clk) disable iff (rst)
        strobe && is_prot && !remote_defect_in && prot_mode_in == PROT_SPRING
        |=> trail_frame_data_out == $past(dat_s2_r))
        else $error("ring code altered");
    chk_error_byte: assert property (@(posedge sys_clk) disable iff (rst)
        strobe && is_err |=> trail_frame_data_out ==
            (($past(remote_error_count_in) > 9'h0FF) ? 8'hFF : $past(remote_error_count_in[7:0])))
        else $error("remote error byte wrong");
    chk_parity_insert: assert property (@(posedge sys_clk) disable iff (rst)
        strobe && is_par |=> trail_frame_data_out == $past(bip_r[cur_lane]))
        else $error("parity byte not from previous frame");
    chk_parity_accum: assert property (@(posedge sys_clk) disable iff (rst)
        strobe && !fs_s2_r && !in_regenerator_overhead |=> acc_r[$past(cur_lane)] ==
            ($past(acc_r[cur_lane]) ^ trail_frame_data_out))
        else $error("parity lane not updated");
    chk_payload_pass: assert property (@(posedge sys_clk) disable iff (rst)
        strobe && !is_par && !is_err && !is_prot
        |=> trail_frame_data_out == $past(dat_s2_r) && trail_frame_start_out == $past(fs_s2_r))
        else $error("payload or start not forwarded");
    chk_clock_follow: assert property (@(posedge sys_clk) disable iff (rst)
        strobe |=> !trail_frame_clock_out ##1 trail_frame_clock_out)
        else $error("output clock edge out of place");
endmodule

// ==== trail_overhead_map.svh ====
// Frame geometry, overhead positions, codes and timing for the trail overhead inserter.
// Assumes 0-based row and column counts of a 9 x 4320 octet frame.
`ifndef TRAIL_OVERHEAD_MAP_SVH
`define TRAIL_OVERHEAD_MAP_SVH

// Frame geometry
`define FRAME_COLS 13'd4320
`define FRAME_ROWS 4'd9
`define REGENERATOR_OVERHEAD_ROWS 4'd3
`define OH_COLS 13'd144
`define BIP_LANES 6'd48
// Parity bytes: row 5, columns 1..48
`define PAR_ROW 4'd4
`define PAR_COL_END 13'd48
// Protection byte two and remote error byte positions
`define PROT_ROW 4'd4
`define PROT_COL 13'd96
`define ERR_ROW 4'd8
`define ERR_COL 13'd98
// Codes in bits 6-8 of the protection byte
`define RDI_CODE 3'h6
`define AIS_CODE 3'h7
`define CLEAR_CODE 3'h0
`define ERR_MAX 8'hFF
// Timing: defect reaction limit counted in frames
`define RDI_LIMIT_US 250
`define FRAME_US 125
`define RDI_LIMIT_FRAMES (`RDI_LIMIT_US / `FRAME_US)

`endif

// ==== trail_overhead_pkg.sv ====
// Types shared by the trail overhead inserter.
// Assumes trail_overhead_map.svh supplies all numeric constants.
package trail_overhead_pkg;
    typedef logic [7:0] octet_t;
    // Protection scheme in use on the section
    typedef enum logic [1:0] {
        PROT_NONE = 2'h0,
        PROT_LINEAR = 2'h1,
        PROT_SPRING = 2'h3
    } prot_mode_t;
endpackage

// ==== frame_source.sv ====
// Model of the adaptation source that feeds the inserter: link clock, frame start, octets.
// Assumes sys_clk is the bench clock; one link octet lasts 8 sys_clk (320 ns).
`timescale 1ns/10ps
module frame_source #(
    parameter int FRAME_LEN = 38880, // Octets per frame
    parameter int PROT_POS = 17376 // Octet index of protection byte two
) (
    input wire logic sys_clk,
    input wire logic run,
    input wire logic [7:0] prot_octet,
    output logic link_clk,
    output logic frame_start,
    output trail_overhead_pkg::octet_t data
);
    import trail_overhead_pkg::*;
    logic [2:0] ph_r; // Phase within one octet
    logic [15:0] idx_r; // Octet index within the frame
    initial begin
        link_clk = 1'b0;
        frame_start = 1'b0;
        data = 8'h00;
        ph_r = 3'h0;
        idx_r = 16'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Data changes with the link clock low, so it is settled long before each rise
    always @(negedge sys_clk) begin
        if (!run) begin
            // Clock stands still while run is low; data toggles so no stale value looks valid
            link_clk <= 1'b0;
            frame_start <= 1'b0;
            data <= ~data;
            ph_r <= 3'h0;
            idx_r <= 16'h0;
        end else begin
            ph_r <= ph_r + 3'h1;
            if (ph_r == 3'h0) begin
                link_clk <= 1'b0;
                frame_start <= (idx_r == 16'h0);
                // Protection byte two carries the octet under test, the rest a count pattern
                data <= (idx_r == 16'(PROT_POS)) ? prot_octet : (idx_r[7:0] ^ 8'h5A);
            end
            if (ph_r == 3'h4) begin
                link_clk <= 1'b1;
            end
            if (ph_r == 3'h7) begin
                // Wrap at the frame end so every frame opens with its own start
                idx_r <= (idx_r == 16'(FRAME_LEN - 1)) ? 16'h0 : idx_r + 16'h1;
            end
        end
    end
endmodule

// ==== ms_trail_overhead_inserter_bench.sv ====
// Self-checking bench for the trail overhead inserter.
// Assumes frame_source as the upstream model; rows are shortened to 192 columns
// so that whole frames, and the parity they carry forward, fit the run time.
`timescale 1ns/10ps
`include "trail_overhead_map.svh"
module ms_trail_overhead_inserter_bench;
    import trail_overhead_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic [7:0] prot_octet = 8'h00;
    logic [8:0] err_in = 9'h000;
    logic defect = 1'b0;
    prot_mode_t mode = PROT_NONE;
    localparam int COLS = 192; // Shortened row, a multiple of the 48 parity lanes
    localparam int FRAME_LEN = 9 * COLS; // Octets per frame
    localparam int PROT_POS = `PROT_ROW * COLS + `PROT_COL; // Protection byte two
    localparam int ERR_POS = `ERR_ROW * COLS + `ERR_COL; // Remote error byte
    logic [2:0] exp_low = 3'h0; // Expected bits 6-8 of the protection byte
    logic [7:0] exp_err = 8'h00; // Expected remote error byte
    logic [7:0] want; // Expected value of the octet being judged
    logic [7:0] par_run [0:47]; // Parity sums of the frame now leaving
    logic [7:0] par_prev [0:47]; // Parity sums of the frame before
    logic hung = 1'b0; // Octet stream stalled; later runs are skipped
    logic lclk, lstart, oclk, ostart;
    logic oclk_d = 1'b0;
    octet_t ldata, odata;
    int err_count = 0;
    int checked = 0;
    int out_idx = -1; // Output octet index since the run began
    int pos, row, col; // Place of the judged octet within its frame
    always #20 sys_clk = ~sys_clk;
    frame_source #(.FRAME_LEN(FRAME_LEN), .PROT_POS(PROT_POS)) frame_source_i (
        .sys_clk(sys_clk), .run(run), .prot_octet(prot_octet),
        .link_clk(lclk), .frame_start(lstart), .data(ldata));
    ms_trail_overhead_inserter #(.NUM_COLS(13'(COLS))) ms_trail_overhead_inserter_i (
        .sys_clk(sys_clk), .rst(rst),
        .adapted_frame_clock_in(lclk), .adapted_frame_start_in(lstart),
        .adapted_frame_data_in(ldata), .remote_error_count_in(err_in),
        .remote_defect_in(defect), .prot_mode_in(mode), .trail_frame_clock_out(oclk),
        .trail_frame_start_out(ostart), .trail_frame_data_out(odata));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Judge each octet at the rise of the forwarded clock, when data has settled
    always @(negedge sys_clk) begin
        if (oclk === 1'b1 && oclk_d === 1'b0) begin
            out_idx = out_idx + 1;
            pos = out_idx % FRAME_LEN;
            row = pos / COLS;
            col = pos % COLS;
            if (pos == 0) begin
                // New frame: the sums of the last one become the parity to expect
                for (int i = 0; i < 48; i++) begin
                    par_prev[i] = par_run[i];
                    par_run[i] = 8'h00;
                end
            end
            check({7'h0, ostart}, {7'h0, pos == 0});
            if (row == `PAR_ROW && col < `PAR_COL_END) begin
                want = par_prev[col];
                check(odata, want);
            end else if (pos == ERR_POS) begin
                want = exp_err;
                check(odata, want);
            end else if (pos == PROT_POS) begin
                want = {prot_octet[7:3], exp_low};
                check(odata, want);
            end else begin
                want = pos[7:0] ^ 8'h5A;
                check(odata, want);
            end
            // Sum what should have left, regenerator overhead excluded
            if (row >= `REGENERATOR_OVERHEAD_ROWS || col >= `OH_COLS) begin
                par_run[col % 48] = par_run[col % 48] ^ want;
            end
        end
        oclk_d = oclk;
    end
    // Synchronous reset between runs; outputs read zero once it is released
    task automatic restart();
        rst <= 1'b1;
        repeat (4) @(negedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        check({6'h0, oclk, ostart}, 8'h00);
        check(odata, 8'h00);
    endtask
    // Run octets 0 to n from a fresh frame start; bounded wait
    task automatic run_octets(input int n);
        int guard;
        guard = 0;
        out_idx = -1;
        for (int i = 0; i < 48; i++) begin
            par_run[i] = 8'h00;
            par_prev[i] = 8'h00;
        end
        run <= 1'b1;
        while (!hung && out_idx < n && guard < n * 8 + 200) begin
            @(negedge sys_clk);
            guard++;
        end
        if (!hung && out_idx < n) begin
            err_count++;
            hung = 1'b1;
            $display("unexpected at %0t: octets stopped", $time);
        end
        run <= 1'b0;
        repeat (20) @(negedge sys_clk);
    endtask
    // Defect in ring mode: defect code wins, small count passes as is
    task automatic test_forward();
        restart();
        mode <= PROT_SPRING;
        defect <= 1'b1;
        err_in <= 9'h003;
        prot_octet <= 8'hAB;
        exp_low <= 3'h6;
        exp_err <= 8'h03;
        run_octets(ERR_POS);
        $display("forward test done");
    endtask
    // Two linear frames: parity of frame one lands in frame two, 111 leaves as 000,
    // a count above 255 saturates
    task automatic test_prot();
        restart();
        mode <= PROT_LINEAR;
        defect <= 1'b0;
        err_in <= 9'h12C;
        prot_octet <= 8'hAF;
        exp_low <= 3'h0;
        exp_err <= 8'hFF;
        run_octets(FRAME_LEN + ERR_POS);
        $display("protection byte test done");
    endtask
    // Ring mode without defect: 111 passes, count of exactly 255 is kept
    task automatic test_ring();
        restart();
        mode <= PROT_SPRING;
        defect <= 1'b0;
        err_in <= 9'h0FF;
        prot_octet <= 8'hAF;
        exp_low <= 3'h7;
        exp_err <= 8'hFF;
        run_octets(ERR_POS);
        $display("ring test done");
    endtask
    // No protection: ordinary code passes, count of 256 saturates
    task automatic test_plain();
        restart();
        mode <= PROT_NONE;
        defect <= 1'b0;
        err_in <= 9'h100;
        prot_octet <= 8'hAA;
        exp_low <= 3'h2;
        exp_err <= 8'hFF;
        run_octets(ERR_POS);
        $display("plain test done");
    endtask
    initial begin
        repeat (10) @(negedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(negedge sys_clk);
        test_forward();
        test_prot();
        test_ring();
        test_plain();
        conclude();
    end
endmodule
